// File: gpx_defines.svh
// Constants for the general-purpose I/O port with external interrupts.
// Assumes it is included by its bare name from the package and the port.
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

// ============================================================
// Bus address width and register byte offsets
`define GPX_AW            8
`define GPX_OFF_DATA      8'h00
`define GPX_OFF_DIR       8'h04
`define GPX_OFF_OPT       8'h08
`define GPX_OFF_SENS      8'h0c
`define GPX_OFF_PEND      8'h10
`define GPX_OFF_MASK      8'h14
`define GPX_OFF_LEVEL     8'h18

// ============================================================
// Reset values
`define GPX_RST_DATA      8'h00
`define GPX_RST_DIR       8'h08
`define GPX_RST_OPT       8'h02
`define GPX_RST_SENS      16'h0000
`define GPX_RST_MASK      8'h00

// ============================================================
// Sensitivity codes, two bits per vector
`define GPX_SENS_FALL_LOW 2'h0
`define GPX_SENS_RISE     2'h1
`define GPX_SENS_FALL     2'h2
`define GPX_SENS_BOTH     2'h3

// ============================================================
// AXI4-Lite response codes
`define GPX_RESP_OKAY     2'h0
`define GPX_RESP_SLVERR   2'h2

`endif

// File: gpx_pkg.sv
// Types shared by the I/O port and its bus wiring.
// Assumes gpx_defines.svh sits in the same folder.
`include "gpx_defines.svh"

package gpx_pkg;

    // ============================================================
    // AXI4-Lite channels, master to slave
    typedef struct packed {
        logic [`GPX_AW-1:0] awaddr;
        logic               awvalid;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               wvalid;
        logic               bready;
        logic [`GPX_AW-1:0] araddr;
        logic               arvalid;
        logic               rready;
    } gpx_axi_req_s;

    // ============================================================
    // AXI4-Lite channels, slave to master
    typedef struct packed {
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } gpx_axi_rsp_s;

endpackage

// File: gpx_sync.sv
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no bus coherency is offered.
`timescale 1ns/1ps
`default_nettype none

module gpx_sync #(
    parameter int          W   = 6,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    // ============================================================
    // First stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST;
            q_o  <= RST;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule

`default_nettype wire

// File: gpx_port.sv
// I/O port with per-pin direction, option and data latch, and external
// interrupt detection per vector, reached over AXI4-Lite.
// Assumes pads are resolved outside from pad_o / pad_oe_n, and the CPU
// pulses vec_ack_i for one cycle when it fetches a vector.
`timescale 1ns/1ps
`default_nettype none
`include "gpx_defines.svh"

module gpx_port
    import gpx_pkg::*;
#(
    parameter int                    NPINS    = 6,
    parameter int                    NVEC     = 6,
    parameter int                    OUT_ONLY = 3,
    parameter logic [NPINS*3-1:0]    VEC_MAP  = 18'h2c688
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire gpx_pkg::gpx_axi_req_s axi_req_i,
    output gpx_pkg::gpx_axi_rsp_s   axi_rsp_o,
    input  wire logic [NPINS-1:0]   pad_i,
    output logic      [NPINS-1:0]   pad_o,
    output logic      [NPINS-1:0]   pad_oe_n_o,
    output logic      [NPINS-1:0]   pull_up_o,
    input  wire logic [NVEC-1:0]    vec_ack_i,
    output logic      [NVEC-1:0]    irq_req_o,
    output logic                    irq_o
);

    import gpx_pkg::*;

    localparam logic [7:0]  RST_DATA = `GPX_RST_DATA;
    localparam logic [7:0]  RST_DIR  = `GPX_RST_DIR;
    localparam logic [7:0]  RST_OPT  = `GPX_RST_OPT;
    localparam logic [15:0] RST_SENS = `GPX_RST_SENS;
    localparam logic [7:0]  RST_MASK = `GPX_RST_MASK;

    // ============================================================
    // All state of the port but the reset and pin synchronisers
    typedef struct packed {
        logic [NPINS-1:0]   latch;
        logic [NPINS-1:0]   dir;
        logic [NPINS-1:0]   opt;
        logic [2*NVEC-1:0]  sens;
        logic [NVEC-1:0]    pend;
        logic [NVEC-1:0]    mask;
        logic [NVEC-1:0]    det_prev;
        logic               aw_got;
        logic [`GPX_AW-1:0] awaddr;
        logic               w_got;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [NPINS-1:0]   pad_o;
        logic [NPINS-1:0]   pad_oe_n;
        logic [NPINS-1:0]   pull_up;
        logic [NVEC-1:0]    irq_req;
        logic               irq;
    } gpx_state_s;

    gpx_state_s       s;
    gpx_state_s       next_s;
    logic [1:0]       rst_sync;
    logic             rst_n;
    logic [NPINS-1:0] pin;

    // ============================================================
    // Expand byte strobes into a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction

    // Does pin p belong to vector v
    function automatic logic on_vec(input int p, input int v);
        return VEC_MAP[p*3 +: 3] == v[2:0];
    endfunction

    // Is the address one of ours
    function automatic logic mapped(input logic [`GPX_AW-1:0] a);
        return a == `GPX_OFF_DATA || a == `GPX_OFF_DIR ||
               a == `GPX_OFF_OPT  || a == `GPX_OFF_SENS ||
               a == `GPX_OFF_PEND || a == `GPX_OFF_MASK ||
               a == `GPX_OFF_LEVEL;
    endfunction

    // ============================================================
    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ============================================================
    // Pads come from outside the clock domain
    gpx_sync #(
        .W   (NPINS),
        .RST ({NPINS{1'b1}})
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .d_i     (pad_i),
        .q_o     (pin)
    );

    // ============================================================
    // Next state: bus slave, registers, detectors, pad drive
    always_comb begin
        logic [NPINS-1:0] int_en;
        logic [NVEC-1:0]  lvl;
        logic [NVEC-1:0]  evt;
        logic [NVEC-1:0]  clr;
        logic [31:0]      wm;
        logic [31:0]      wd;
        logic             wr;
        logic [31:0]      rd;
        logic [2*NVEC-1:0] new_sens;
        logic [1:0]       code;
        int_en   = '0;
        lvl      = '0;
        evt      = '0;
        clr      = '0;
        wm       = strb_mask(s.wstrb);
        wd       = s.wdata;
        wr       = s.aw_got & s.w_got & ~s.bvalid;
        rd       = '0;
        new_sens = s.sens;
        code     = 2'h0;
        next_s   = s;

        // Write address and data may arrive in either order
        if (axi_req_i.awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = axi_req_i.wdata;
            next_s.wstrb = axi_req_i.wstrb;
        end
        if (s.bvalid && axi_req_i.bready) begin
            next_s.bvalid = 1'b0;
        end

        // Register writes once both halves are held
        if (wr) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = mapped(s.awaddr) ? `GPX_RESP_OKAY
                                             : `GPX_RESP_SLVERR;
            unique case (s.awaddr)
                `GPX_OFF_DATA: begin
                    next_s.latch = (s.latch & ~wm[NPINS-1:0]) |
                                   (wd[NPINS-1:0] & wm[NPINS-1:0]);
                end
                `GPX_OFF_DIR: begin
                    next_s.dir = (s.dir & ~wm[NPINS-1:0]) |
                                 (wd[NPINS-1:0] & wm[NPINS-1:0]);
                end
                `GPX_OFF_OPT: begin
                    next_s.opt = (s.opt & ~wm[NPINS-1:0]) |
                                 (wd[NPINS-1:0] & wm[NPINS-1:0]);
                end
                `GPX_OFF_SENS: begin
                    new_sens = (s.sens & ~wm[2*NVEC-1:0]) |
                               (wd[2*NVEC-1:0] & wm[2*NVEC-1:0]);
                    next_s.sens = new_sens;
                end
                `GPX_OFF_PEND: begin
                    clr = wd[NVEC-1:0] & wm[NVEC-1:0];
                end
                `GPX_OFF_MASK: begin
                    next_s.mask = (s.mask & ~wm[NVEC-1:0]) |
                                  (wd[NVEC-1:0] & wm[NVEC-1:0]);
                end
                default: begin
                end
            endcase
        end

        // The output-only pin cannot be turned into an input
        next_s.dir[OUT_ONLY] = 1'b1;

        // Reads answer the cycle after the address is taken
        if (s.rvalid && axi_req_i.rready) begin
            next_s.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && s.arready) begin
            unique case (axi_req_i.araddr)
                `GPX_OFF_DATA: begin
                    rd[NPINS-1:0] = (s.dir & s.latch) | (~s.dir & pin);
                end
                `GPX_OFF_DIR:   rd[NPINS-1:0]  = s.dir;
                `GPX_OFF_OPT:   rd[NPINS-1:0]  = s.opt;
                `GPX_OFF_SENS:  rd[2*NVEC-1:0] = s.sens;
                `GPX_OFF_PEND:  rd[NVEC-1:0]   = s.pend;
                `GPX_OFF_MASK:  rd[NVEC-1:0]   = s.mask;
                `GPX_OFF_LEVEL: rd[NPINS-1:0]  = pin;
                default:        rd = '0;
            endcase
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd;
            next_s.rresp  = mapped(axi_req_i.araddr) ? `GPX_RESP_OKAY
                                                     : `GPX_RESP_SLVERR;
        end

        // Detector inputs: disabled pins read as one, so a low enabled
        // pin can hold the whole vector low and hide its neighbours
        int_en = ~s.dir & s.opt;
        for (int v = 0; v < NVEC; v++) begin
            lvl[v] = 1'b1;
            for (int p = 0; p < NPINS; p++) begin
                if (on_vec(p, v) && int_en[p]) begin
                    lvl[v] = lvl[v] & pin[p];
                end
            end
            code = s.sens[v*2 +: 2];
            unique case (code)
                `GPX_SENS_FALL_LOW: evt[v] = ~lvl[v];
                `GPX_SENS_RISE:     evt[v] = lvl[v] & ~s.det_prev[v];
                `GPX_SENS_FALL:     evt[v] = ~lvl[v] & s.det_prev[v];
                default:            evt[v] = lvl[v] ^ s.det_prev[v];
            endcase
            if (new_sens[v*2 +: 2] != s.sens[v*2 +: 2]) begin
                clr[v] = 1'b1;
            end
        end
        next_s.det_prev = lvl;
        clr = clr | vec_ack_i;

        // A new event outweighs a clear in the same cycle
        next_s.pend = (s.pend & ~clr) | evt;

        // Bus readiness follows the held halves and open answers
        next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
        next_s.wready  = ~next_s.w_got & ~next_s.bvalid;
        next_s.arready = ~next_s.rvalid;

        // Pad drive from the settled registers
        next_s.pad_o    = next_s.latch;
        next_s.pad_oe_n = ~(next_s.dir &
                            (next_s.opt | ~next_s.latch));
        next_s.pull_up  = ~next_s.dir & next_s.opt;
        next_s.irq_req  = next_s.pend;
        next_s.irq      = |(next_s.pend & next_s.mask);
    end

    // ============================================================
    // State register; detectors start high so reset gives no edge
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s          <= '0;
            s.latch    <= RST_DATA[NPINS-1:0];
            s.dir      <= RST_DIR[NPINS-1:0];
            s.opt      <= RST_OPT[NPINS-1:0];
            s.sens     <= RST_SENS[2*NVEC-1:0];
            s.mask     <= RST_MASK[NVEC-1:0];
            s.det_prev <= '1;
            s.pad_oe_n <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs straight from the state register
    assign axi_rsp_o.awready = s.awready;
    assign axi_rsp_o.wready  = s.wready;
    assign axi_rsp_o.bvalid  = s.bvalid;
    assign axi_rsp_o.bresp   = s.bresp;
    assign axi_rsp_o.arready = s.arready;
    assign axi_rsp_o.rvalid  = s.rvalid;
    assign axi_rsp_o.rdata   = s.rdata;
    assign axi_rsp_o.rresp   = s.rresp;
    assign pad_o             = s.pad_o;
    assign pad_oe_n_o        = s.pad_oe_n;
    assign pull_up_o         = s.pull_up;
    assign irq_req_o         = s.irq_req;
    assign irq_o             = s.irq;

endmodule

`default_nettype wire

// File: gpx_pad_model.sv
// Pad and line model that stands outside the I/O port.
// Assumes the bench sets the external drivers; pads resolve here.
`timescale 1ns/1ps
`default_nettype none

module gpx_pad_model (
    input  wire logic       clk_i,
    input  wire logic [5:0] pad_o_i,
    input  wire logic [5:0] pad_oe_n_i,
    input  wire logic [5:0] pull_up_i,
    input  wire logic [5:0] ext_en_i,
    input  wire logic [5:0] ext_v_i,
    output logic      [5:0] pin_o
);
    // ============================================================
    // Wire resolution
    logic [5:0] wander;
    // Undriven lines wander so a stale level is never trusted
    always_ff @(posedge clk_i) begin
        wander <= ~pin_o;
    end
    // Port drive wins, then the outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pad_oe_n_i[i]) begin
                pin_o[i] = pad_o_i[i];
            end else if (ext_en_i[i]) begin
                pin_o[i] = ext_v_i[i];
            end else begin
                pin_o[i] = pull_up_i[i] ? 1'b1 : wander[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: gpx_port_chk.sv
// Concurrent checks on the I/O port top-level ports.
// Assumes bind to gpx_port with the identity map for vector 1.
`timescale 1ns/1ps
`default_nettype none

module gpx_port_chk
    import gpx_pkg::*;
#(
    parameter int NPINS = 6,
    parameter int NVEC  = 6
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire gpx_pkg::gpx_axi_req_s axi_req_i,
    input  wire gpx_pkg::gpx_axi_rsp_s axi_rsp_o,
    input  wire logic [NPINS-1:0]      pad_i,
    input  wire logic [NPINS-1:0]      pad_o,
    input  wire logic [NPINS-1:0]      pad_oe_n_o,
    input  wire logic [NPINS-1:0]      pull_up_o,
    input  wire logic [NVEC-1:0]       vec_ack_i,
    input  wire logic [NVEC-1:0]       irq_req_o,
    input  wire logic                  irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ============================================================
    // Settle counter, reset release runs through a synchroniser
    logic [2:0] up_cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    // ============================================================
    // Assertions
    AST_PIN3_OUT: assert property (up_cnt == 3'h7 && pad_oe_n_o[3]
        |-> pad_o[3]) else $error("output-only pin released at 0");
    AST_PULL_OUT: assert property ((pull_up_o & ~pad_oe_n_o) == '0)
        else $error("pull-up on a driven pin");
    AST_ACK_CLR: assert property (vec_ack_i[1] && irq_req_o[1]
        && pad_i[1] && pad_i == $past(pad_i) && pad_i == $past(pad_i, 2)
        && pad_i == $past(pad_i, 3) |=> !irq_req_o[1])
        else $error("vector fetch left request pending");
    AST_IRQ_SRC: assert property (irq_o
        |-> (|irq_req_o))
        else $error("interrupt without pending request");
    AST_WR_LAT: assert property (axi_req_i.awvalid && axi_rsp_o.awready
        && axi_req_i.wvalid && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
        else $error("write answer late");
    AST_RD_LAT: assert property (axi_req_i.arvalid && axi_rsp_o.arready
        |=> axi_rsp_o.rvalid) else $error("read answer late");
    AST_B_HOLD: assert property (axi_rsp_o.bvalid && !axi_req_i.bready
        |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (axi_rsp_o.rvalid && !axi_req_i.rready
        |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
        else $error("read data dropped");
    // Main scenarios reached
    COV_IRQ: cover property ($rose(irq_o));
    COV_ACK: cover property (vec_ack_i[1] && irq_req_o[1]);
    COV_ERR: cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == 2'h2);
endmodule

bind gpx_port gpx_port_chk #(.NPINS(NPINS), .NVEC(NVEC)) gpx_port_chk_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .axi_req_i(axi_req_i),
    .axi_rsp_o(axi_rsp_o), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_n_o(pad_oe_n_o), .pull_up_o(pull_up_o),
    .vec_ack_i(vec_ack_i), .irq_req_o(irq_req_o), .irq_o(irq_o));
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the I/O port over AXI4-Lite.
// Assumes the pad model resolves pins; pin 2 shares vector 0.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import gpx_pkg::*;
    logic clk_i, rst_n_i;
    gpx_axi_req_s req;
    gpx_axi_rsp_s rsp;
    logic [5:0] pin, pad_o, oe_n, pull, ack, irq_req, ext;
    logic irq;
    logic [31:0] rd_d;
    logic [1:0] resp;
    int n_fail, compares;
    // ============================================================
    // Design and far side
    gpx_port #(.VEC_MAP(18'h2c608)) gpx_port_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .axi_req_i(req), .axi_rsp_o(rsp), .pad_i(pin),
        .pad_o(pad_o), .pad_oe_n_o(oe_n), .pull_up_o(pull), .vec_ack_i(ack),
        .irq_req_o(irq_req), .irq_o(irq));
    gpx_pad_model gpx_pad_model_inst (.clk_i(clk_i), .pad_o_i(pad_o),
        .pad_oe_n_i(oe_n), .pull_up_i(pull), .ext_en_i(6'h3f),
        .ext_v_i(ext), .pin_o(pin));
    // Clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ============================================================
    // Tasks
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Write: both halves offered together, each dropped once taken
    // A late master raises bready only once it sees bvalid
    task automatic wr(logic [7:0] a, logic [31:0] d, bit late = 1'b0);
        int n;
        @(posedge clk_i);
        req.awaddr <= a; req.awvalid <= 1'b1; req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1; req.bready <= !late;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) break;
            if (rsp.bvalid) req.bready <= 1'b1;
        end
        req.bready <= 1'b0;
        resp = rsp.bresp;
        if (n == 50) n_fail++;
    endtask
    task automatic rd(logic [7:0] a, bit late = 1'b0);
        int n;
        @(posedge clk_i);
        req.araddr <= a; req.arvalid <= 1'b1; req.rready <= !late;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) break;
            if (rsp.rvalid) req.rready <= 1'b1;
        end
        req.rready <= 1'b0;
        rd_d = rsp.rdata;
        resp = rsp.rresp;
        if (n == 50) n_fail++;
    endtask
    // Read and compare in one call
    task automatic rc(logic [7:0] a, logic [31:0] e);
        rd(a);
        chk($sformatf("reg %h", a), rd_d, e);
    endtask
    task automatic pin1(logic v);
        ext[1] <= v;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog, tests need a few hundred cycles
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
    // ============================================================
    // Main sequence
    initial begin
        req = '0; ack = 6'h00; ext = 6'h27; rst_n_i = 1'b0;
        n_fail = 0; compares = 0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        // Reset state and pad configuration
        rc(8'h04, 32'h08); rc(8'h08, 32'h02); rc(8'h0c, 32'h0);
        rc(8'h10, 32'h0); rc(8'h14, 32'h0); rc(8'h00, 32'h27);
        chk("pull", pull, 6'h02);
        chk("oe_n", oe_n, 6'h37);
        // Unmapped place refuses
        rd(8'h1c, 1'b1); chk("rresp", resp, 2'h2); chk("rdata", rd_d, 32'h0);
        wr(8'h1c, 32'h3f, 1'b1); chk("bresp", resp, 2'h2);
        // Latch writes on inputs stay inside; output-only pin floats
        wr(8'h00, 32'h3f);
        chk("bresp_ok", resp, 2'h0);
        rc(8'h00, 32'h2f);
        chk("oe_n3", oe_n[3], 1'b1);
        wr(8'h04, 32'h01); rc(8'h04, 32'h09);
        wr(8'h08, 32'h03);
        wr(8'h00, 32'h3e); rc(8'h00, 32'h2e);
        chk("pp", {oe_n[0], pad_o[0]}, 2'b00);
        wr(8'h08, 32'h02); wr(8'h00, 32'h01);
        chk("od", oe_n, 6'h37);
        wr(8'h04, 32'h00);
        // Every sensitivity code on vector 1
        for (int c = 0; c < 4; c++) begin
            wr(8'h0c, 32'(c) << 2);
            pin1(1'b0);
            chk("fall", irq_req[1], 1'(c != 1));
            wr(8'h10, 32'h02);
            pin1(1'b1);
            chk("rise", irq_req[1], 1'(c != 2));
            wr(8'h10, 32'h02);
        end
        rc(8'h10, 32'h0);
        // Fetch clear, sensitivity-change clear, masking
        wr(8'h14, 32'h02); wr(8'h0c, 32'h04);
        pin1(1'b0); pin1(1'b1);
        chk("irq", {irq, irq_req}, 7'h42);
        @(posedge clk_i); ack <= 6'h02;
        @(posedge clk_i); ack <= 6'h00;
        repeat (2) @(posedge clk_i);
        chk("ack", {irq, irq_req}, 7'h00);
        pin1(1'b0); pin1(1'b1);
        wr(8'h0c, 32'h08); chk("sens", irq_req, 6'h00);
        pin1(1'b0); wr(8'h14, 32'h00); @(posedge clk_i);
        chk("mask", {irq, irq_req}, 7'h02);
        wr(8'h10, 32'h02);
        // Safe enable and disable of pin 4 while it sits low, then an unsafe enable that raises a request
        wr(8'h0c, 32'h100); wr(8'h08, 32'h12); wr(8'h0c, 32'h200);
        wr(8'h0c, 32'h200); wr(8'h08, 32'h02); wr(8'h0c, 32'h100);
        chk("safe", irq_req[4], 1'b0);
        wr(8'h0c, 32'h200); wr(8'h08, 32'h12);
        repeat (6) @(posedge clk_i);
        chk("spur", irq_req[4], 1'b1);
        // Pins 0 and 2 share vector 0 and are combined
        ext[0] <= 1'b0; ext[2] <= 1'b0;
        wr(8'h0c, 32'h001); wr(8'h08, 32'h07);
        ext[0] <= 1'b1; repeat (8) @(posedge clk_i);
        chk("and", irq_req[0], 1'b0);
        ext[2] <= 1'b1; repeat (8) @(posedge clk_i);
        chk("and2", irq_req[0], 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
